// ===== psv_sequencer.v
// Purpose: Program sequencer, four-phase cycle, fetch/execute pipeline, vectors
// Assumes: ROM answers rom_data for rom_addr within one instruction cycle
// Notes: Core decoder drives exec_* controls for the word on instr_word
//
// Summary of operation
// - System clock divided into four phases; one instruction cycle is four clocks.
// - Next word is fetched while the previous word executes.
// - Any program counter change flushes the prefetched word as a dummy cycle.
// - Program counter is 13 bits, 8192 words within the selected bank.
// - Program counter advances by one after each fetch.
// - True skip discards the prefetched word and continues at address plus two.
// - Low byte at data address 06H; write replaces bits 7..0, short jump.
// - Jump and call load bits 12..0 from code, bit 13 from bank bit 5.
// - Full 14-bit destination latched when the jump or call executes.
// - Interrupt saves 14-bit return address; return restores it with the bank.
// - Every interrupt vector lies in bank 0.
// - Reset clears the program counter; execution starts at 000H in bank 0.
// - Enabled external interrupt vectors to 004H when the stack is not full.
// - Enabled timer counter 0 overflow vectors to 008H when stack not full.
// - Timer 2 vectors to 010H, timer 3 to 014H, when enabled, stack not full.
// - Converter buffer-empty interrupt vectors to 018H when enabled, stack not full.
// - ROM spans 16384 words in two banks; bank 1 is 2000H to 3FFFH.
// - Power-up or wake from halt holds execution for 1024 clock periods.
// - Call or interrupt pushes 14-bit address onto eight-level stack; return pops.
// - With the stack full, interrupt requests stay pending until a return.
`timescale 1ns/1ps
`include "psv_regs.vh"

module psv_sequencer #(
    parameter PC_W = 13,
    parameter STACK_DEPTH = 8,
    parameter STARTUP_CYC = `PSV_STARTUP_CYC
)
(
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Program ROM
    output reg [PC_W:0] rom_addr,
    input wire [15:0] rom_data,
    // Core decoder side
    output reg [3:0] phase,
    output reg [15:0] instr_word,
    output reg instr_valid,
    input wire exec_jump,
    input wire exec_call,
    input wire exec_return,
    input wire exec_skip,
    input wire exec_halt,
    // Interrupt sources
    input wire ext_int_n,
    input wire tmr0_ovf,
    input wire tmr2_ovf,
    input wire tmr3_ovf,
    input wire dac_latched,
    // Wake-up pin
    input wire wake_n,
    // Status
    output reg running
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam ST_START = 2'b00;
    localparam ST_RUN = 2'b01;
    localparam ST_HALT = 2'b10;

    reg [1:0] state;
    reg [1:0] ph_cnt;
    reg [10:0] start_cnt;
    reg [PC_W:0] pc;
    reg flush;
    reg [7:0] rom_bank_select;
    reg [4:0] irq_en;
    reg [4:0] irq_pend;
    reg [PC_W:0] stack_mem [0:STACK_DEPTH-1];
    reg [2:0] sp;
    reg [3:0] depth;
    reg low_wr_pend;
    reg [7:0] low_wr_val;
    reg ext_s1;
    reg ext_s2;
    reg ext_s3;
    reg wake_s1;
    reg wake_s2;
    reg dp_wr;
    reg [11:0] dp_addr;
    reg [PC_W:0] next_pc;
    reg do_push;
    reg do_pop;
    reg do_flush;
    reg [4:0] ack_mask;

    wire cyc_end;
    wire stack_full;
    wire [4:0] irq_ready;
    wire irq_take;
    wire ap_valid;
    wire ext_fall;
    wire [4:0] irq_new;
    wire [PC_W:0] pc_inc;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Lowest vector among pending enabled sources
    function [PC_W:0] vec_of;
        input [4:0] req;
        begin
            if (req[0])
                vec_of = `PSV_VEC_EXT;
            else if (req[1])
                vec_of = `PSV_VEC_TMR0;
            else if (req[2])
                vec_of = `PSV_VEC_TMR2;
            else if (req[3])
                vec_of = `PSV_VEC_TMR3;
            else
                vec_of = `PSV_VEC_DAC;
        end
    endfunction

    // One-hot of the winning source
    function [4:0] first_of;
        input [4:0] req;
        begin
            first_of = req & (~req + 5'h01);
        end
    endfunction

    // Advance within the bank, bank bit untouched
    function [PC_W:0] bump;
        input [PC_W:0] a;
        begin
            bump = {a[PC_W], a[PC_W-1:0] + {{(PC_W-1){1'b0}}, 1'b1}};
        end
    endfunction

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Two flops per pin, third flop for falling edge
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_s1 <= 1'b1;
            ext_s2 <= 1'b1;
            ext_s3 <= 1'b1;
            wake_s1 <= 1'b1;
            wake_s2 <= 1'b1;
        end
        else
        begin
            ext_s1 <= ext_int_n;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            wake_s1 <= wake_n;
            wake_s2 <= wake_s1;
        end
    end

    assign ext_fall = ext_s3 & ~ext_s2;
    assign irq_new = {dac_latched, tmr3_ovf, tmr2_ovf, tmr0_ovf, ext_fall};

    // ****************************************************************
    // Phase generator and start-up timer
    // ****************************************************************
    assign cyc_end = (state == ST_RUN) && (ph_cnt == 2'd3);

    // Four phases per cycle, start-up hold, halt and wake
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= ST_START;
            ph_cnt <= 2'd0;
            start_cnt <= 11'd0;
            phase <= 4'h0;
            running <= 1'b0;
        end
        else
        begin
            case (state)
                ST_START:
                begin
                    ph_cnt <= 2'd0;
                    phase <= 4'h0;
                    if (start_cnt == STARTUP_CYC[10:0] - 11'd1)
                    begin
                        start_cnt <= 11'd0;
                        state <= ST_RUN;
                        running <= 1'b1;
                        phase <= 4'h1;
                    end
                    else
                        start_cnt <= start_cnt + 11'd1;
                end
                ST_RUN:
                begin
                    ph_cnt <= ph_cnt + 2'd1;
                    phase <= {phase[2:0], phase[3]};
                    if (cyc_end && exec_halt && instr_valid && !flush)
                    begin
                        state <= ST_HALT;
                        running <= 1'b0;
                        phase <= 4'h0;
                    end
                end
                ST_HALT:
                begin
                    if (!wake_s2)
                        state <= ST_START;
                end
                default:
                    state <= ST_START;
            endcase
        end
    end

    // ****************************************************************
    // Next program counter selection
    // ****************************************************************
    assign stack_full = (depth == STACK_DEPTH[3:0]);
    assign irq_ready = irq_pend & irq_en;
    assign pc_inc = bump(pc);
    // Interrupts wait for an ordinary cycle and a free stack level
    assign irq_take = (|irq_ready) && !stack_full && !flush && !low_wr_pend
        && !(instr_valid && (exec_jump || exec_call || exec_return || exec_skip));

    always @*
    begin
        next_pc = pc_inc;
        do_push = 1'b0;
        do_pop = 1'b0;
        do_flush = 1'b0;
        ack_mask = 5'h00;
        if (flush)
            next_pc = pc_inc;
        else if (instr_valid && exec_return)
        begin
            next_pc = stack_mem[sp];
            do_pop = 1'b1;
            do_flush = 1'b1;
        end
        else if (instr_valid && (exec_jump || exec_call))
        begin
            next_pc = {rom_bank_select[`PSV_BANK_BIT], instr_word[PC_W-1:0]};
            do_push = exec_call;
            do_flush = 1'b1;
        end
        else if (instr_valid && exec_skip)
        begin
            next_pc = pc_inc;
            do_flush = 1'b1;
        end
        else if (low_wr_pend)
        begin
            next_pc = {pc[PC_W:8], low_wr_val};
            do_flush = 1'b1;
        end
        else if (irq_take)
        begin
            next_pc = vec_of(irq_ready);
            ack_mask = first_of(irq_ready);
            do_push = 1'b1;
            do_flush = 1'b1;
        end
    end

    // ****************************************************************
    // Fetch and execute pipeline
    // ****************************************************************
    // Word fetched this cycle executes next cycle
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pc <= `PSV_RST_PC;
            rom_addr <= `PSV_RST_PC;
            instr_word <= 16'h0000;
            instr_valid <= 1'b0;
            flush <= 1'b0;
        end
        else if (cyc_end)
        begin
            pc <= next_pc;
            rom_addr <= next_pc;
            instr_word <= rom_data;
            instr_valid <= ~do_flush;
            flush <= do_flush;
        end
        else if (state == ST_START)
            instr_valid <= 1'b0;
    end

    // ****************************************************************
    // Return stack
    // ****************************************************************
    // Circular store: push past eight levels drops the oldest entry
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sp <= 3'd0;
            depth <= 4'd0;
        end
        else if (cyc_end && do_push)
        begin
            sp <= sp + 3'd1;
            if (!stack_full)
                depth <= depth + 4'd1;
        end
        else if (cyc_end && do_pop)
        begin
            sp <= sp - 3'd1;
            if (depth != 4'd0)
                depth <= depth - 4'd1;
        end
    end

    // Return address is the discarded prefetch address
    always @(posedge hclk)
    begin
        if (cyc_end && do_push)
            stack_mem[sp + 3'd1] <= pc;
    end

    // ****************************************************************
    // Interrupt request flags
    // ****************************************************************
    // New event wins over an acknowledge or a software clear
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_pend <= 5'h00;
        else
        begin
            irq_pend <= (irq_pend & ~(cyc_end ? ack_mask : 5'h00)
                & ~((dp_wr && dp_addr == `PSV_ADDR_IRQ_PEND) ? hwdata[4:0] : 5'h00))
                | irq_new;
        end
    end

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ap_valid = hsel && hready && htrans[1];

    // Address phase capture and registered read data
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr <= 1'b0;
            dp_addr <= 12'h000;
            hrdata <= 32'h00000000;
        end
        else
        begin
            dp_wr <= ap_valid && hwrite;
            dp_addr <= haddr[11:0];
            if (ap_valid && !hwrite)
            begin
                case (haddr[11:0])
                    `PSV_ADDR_BANK: hrdata <= {24'h000000, rom_bank_select};
                    `PSV_ADDR_PC_LOW: hrdata <= {24'h000000, pc[7:0]};
                    `PSV_ADDR_IRQ_EN: hrdata <= {27'h0000000, irq_en};
                    `PSV_ADDR_IRQ_PEND: hrdata <= {27'h0000000, irq_pend};
                    `PSV_ADDR_STATUS: hrdata <= {10'h000, pc, 1'b0, state == ST_START,
                        state == ST_HALT, running, depth};
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Register writes in the data phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rom_bank_select <= `PSV_RST_BANK;
            irq_en <= `PSV_RST_IRQ_EN;
            low_wr_pend <= 1'b0;
            low_wr_val <= 8'h00;
        end
        else
        begin
            if (dp_wr && dp_addr == `PSV_ADDR_BANK)
                rom_bank_select <= hwdata[7:0];
            if (dp_wr && dp_addr == `PSV_ADDR_IRQ_EN)
                irq_en <= hwdata[4:0];
            if (dp_wr && dp_addr == `PSV_ADDR_PC_LOW)
            begin
                low_wr_pend <= 1'b1;
                low_wr_val <= hwdata[7:0];
            end
            else if (cyc_end && !flush && !(instr_valid && (exec_return || exec_jump || exec_call || exec_skip)))
                low_wr_pend <= 1'b0;
        end
    end

endmodule // psv_sequencer

// ===== psv_regs.vh
// Purpose: Constants for the program sequencer with interrupt vectors
// Assumes: Included by psv_sequencer.v only
// Notes: Register byte address is four times the register index
`ifndef PSV_REGS_VH
`define PSV_REGS_VH

// ****************************************************************
// Register indices and byte addresses
// ****************************************************************
`define PSV_IDX_BANK 10'h004
`define PSV_IDX_PC_LOW 10'h006
`define PSV_ADDR_BANK ({`PSV_IDX_BANK, 2'b00})
`define PSV_ADDR_PC_LOW ({`PSV_IDX_PC_LOW, 2'b00})
`define PSV_ADDR_IRQ_EN 12'h100
`define PSV_ADDR_IRQ_PEND 12'h104
`define PSV_ADDR_STATUS 12'h108

// ****************************************************************
// Field positions
// ****************************************************************
`define PSV_BANK_BIT 5
`define PSV_ST_DEPTH_LSB 0
`define PSV_ST_RUN_BIT 4
`define PSV_ST_HALT_BIT 5
`define PSV_ST_START_BIT 6
`define PSV_ST_PC_LSB 8

// ****************************************************************
// Reset values
// ****************************************************************
`define PSV_RST_PC 14'h0000
`define PSV_RST_BANK 8'h00
`define PSV_RST_IRQ_EN 5'h00

// ****************************************************************
// Vector addresses, all in bank 0
// ****************************************************************
`define PSV_VEC_EXT 14'h0004
`define PSV_VEC_TMR0 14'h0008
`define PSV_VEC_TMR2 14'h0010
`define PSV_VEC_TMR3 14'h0014
`define PSV_VEC_DAC 14'h0018

// ****************************************************************
// Timing
// ****************************************************************
`define PSV_PHASES 4
`define PSV_STARTUP_TSYS 1024
`define PSV_STARTUP_CYC (`PSV_STARTUP_TSYS * 1)

`endif

// ===== psv_seq_props.sv
// Purpose: Port checker for the program sequencer
// Assumes: Bound to psv_sequencer; exec inputs sampled at cycle end
// Notes: Start-up length comes in as a parameter
`timescale 1ns/1ps
module psv_seq_props #(
    parameter PC_W = 13,
    parameter STARTUP_CYC = 16
)
(
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Sequencer outputs
    input wire [3:0] phase,
    input wire running,
    input wire [PC_W:0] rom_addr,
    input wire [15:0] instr_word,
    input wire instr_valid,
    // ROM and decoder inputs
    input wire [15:0] rom_data,
    input wire exec_jump,
    input wire exec_call,
    input wire exec_return,
    input wire exec_skip
);
    // ****************************************
    // Helper logic and properties
    // ****************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    reg [11:0] idle_cnt;
    reg cold;
    wire fin = running && phase == 4'b1000;
    wire act = fin && instr_valid;
    wire xfer = exec_jump || exec_call || exec_return || exec_skip;
    // Clocks spent idle, and whether no start has happened since reset
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            idle_cnt <= 12'h000;
            cold <= 1'b1;
        end
        else
        begin
            idle_cnt <= running ? 12'h000 : (idle_cnt == 12'hFFF ? idle_cnt : idle_cnt + 12'h001);
            cold <= cold && !running;
        end
    end
    property p_phase_seq;
        running && phase == 4'b0001 |=> phase == 4'b0010 ##1 phase == 4'b0100 ##1 phase == 4'b1000;
    endproperty
    a_phase_seq: assert property (p_phase_seq) else $error("phase order broken");
    property p_idle_phase;
        !running |-> phase == 4'b0000;
    endproperty
    a_idle_phase: assert property (p_idle_phase) else $error("phase active while idle");
    property p_fetch_hold;
        running && phase != 4'b1000 |=> $stable(rom_addr);
    endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("fetch address moved mid cycle");
    property p_word_load;
        fin |=> (instr_valid |-> instr_word == $past(rom_data));
    endproperty
    a_word_load: assert property (p_word_load) else $error("executed word not the fetched one");
    property p_dummy;
        act && xfer |=> !instr_valid [*4];
    endproperty
    a_dummy: assert property (p_dummy) else $error("no dummy cycle after transfer");
    property p_jump;
        act && exec_jump && !exec_return |=> rom_addr[12:0] == $past(instr_word[12:0]);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target wrong");
    property p_skip;
        act && exec_skip && !exec_jump && !exec_call && !exec_return
            |=> rom_addr == {$past(rom_addr[PC_W]), $past(rom_addr[PC_W-1:0]) + 1'b1};
    endproperty
    a_skip: assert property (p_skip) else $error("skip address wrong");
    property p_startup;
        $rose(running) |-> idle_cnt >= STARTUP_CYC;
    endproperty
    a_startup: assert property (p_startup) else $error("start-up hold too short");
    property p_cold;
        $rose(running) && cold |-> rom_addr == 0;
    endproperty
    a_cold: assert property (p_cold) else $error("first fetch not at zero");
    c_jump: cover property (act && exec_jump);
    c_return: cover property (act && exec_return);
    c_skip: cover property (act && exec_skip);
    c_wake: cover property ($rose(running) && !cold);
endmodule // psv_seq_props

// ===== psv_rom_model.sv
// Purpose: Program ROM model for the sequencer bench
// Assumes: Word is read back combinationally
// Notes: Each word encodes its own address for predictable targets
`timescale 1ns/1ps
module psv_rom_model #(
    parameter PC_W = 13
)
(
    // Fetch address
    input wire [PC_W:0] rom_addr,
    // Word at that address
    output wire [15:0] rom_data
);
    // Full 14-bit space of 16-bit words, both banks
    assign rom_data = {2'b10, rom_addr ^ 14'h0AAA};
endmodule // psv_rom_model

// ===== psv_sequencer_tb_top.sv
// Purpose: Self-checking bench for the program sequencer
// Assumes: Zero-wait slave, short start-up parameter
// Notes: Bench acts as decoder and interrupt sources
`timescale 1ns/1ps
module psv_sequencer_tb_top;
    // ****************************************
    // Signals, tasks and sequence
    // ****************************************
    localparam ST = 16;
    reg hclk;
    reg hresetn;
    reg hsel;
    reg [31:0] haddr;
    reg [1:0] htrans;
    reg hwrite;
    reg [31:0] hwdata;
    reg [4:0] ex;
    reg [4:0] src;
    reg wake_n;
    wire hreadyout;
    wire hresp;
    wire [31:0] hrdata;
    wire [13:0] rom_addr;
    wire [15:0] rom_data;
    wire [3:0] phase;
    wire [15:0] instr_word;
    wire instr_valid;
    wire running;
    integer error_cnt;
    integer check_count;
    integer n;
    reg [13:0] k;
    reg [13:0] pre;
    reg [13:0] ra;
    reg [13:0] r1;
    reg [31:0] rd;
    psv_sequencer #(.STARTUP_CYC(ST)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rom_addr(rom_addr), .rom_data(rom_data),
        .phase(phase), .instr_word(instr_word), .instr_valid(instr_valid), .exec_jump(ex[0]),
        .exec_call(ex[1]), .exec_return(ex[2]), .exec_skip(ex[3]), .exec_halt(ex[4]), .ext_int_n(~src[0]),
        .tmr0_ovf(src[1]), .tmr2_ovf(src[2]), .tmr3_ovf(src[3]), .dac_latched(src[4]),
        .wake_n(wake_n), .running(running));
    psv_rom_model #(.PC_W(13)) rom (.rom_addr(rom_addr), .rom_data(rom_data));
    function [13:0] tgt(input b, input [13:0] p);
        tgt = {b, (p[12:0] - 13'h1) ^ 13'h0AAA};
    endfunction
    function [13:0] vaddr(input [2:0] v);
        case (v)
            3'd0: vaddr = 14'h0004;
            3'd1: vaddr = 14'h0008;
            3'd2: vaddr = 14'h0010;
            3'd3: vaddr = 14'h0014;
            default: vaddr = 14'h0018;
        endcase
    endfunction
    task chk(input [31:0] g, input [31:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e)
            begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    // One single AHB transfer; read data lands in rd
    task ahb(input w, input [31:0] a, input [31:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            haddr <= a;
            hwrite <= w;
            htrans <= 2'b10;
            do @(posedge hclk); while (hreadyout !== 1'b1);
            htrans <= 2'b00;
            hwdata <= d;
            do @(posedge hclk); while (hreadyout !== 1'b1);
            rd = hrdata;
            hsel <= 1'b0;
        end
    endtask
    // Hold decoder controls over the last phase of one cycle
    task cyc(input [4:0] e);
        begin
            do @(posedge hclk); while (phase !== 4'b0100);
            ex <= e;
            @(posedge hclk);
            pre = rom_addr;
            ex <= 5'h00;
            #1;
        end
    endtask
    task pulse(input [4:0] m);
        begin
            @(posedge hclk);
            src <= m;
            @(posedge hclk);
            src <= m & 5'h01;
        end
    endtask
    // Wait for a vector fetch; ra keeps the address it replaced
    task vec(input [13:0] v);
        begin
            n = 0;
            do
            begin
                ra = rom_addr;
                @(posedge hclk);
                #1;
                n = n + 1;
            end
            while (rom_addr !== v && n < 40);
            chk(rom_addr, v);
        end
    endtask
    task conclude;
        begin
            $display("Checks %0d mismatches %0d", check_count, error_cnt);
            if (error_cnt == 0 && check_count > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // Clock
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // Watchdog
    initial
    begin
        #200000;
        error_cnt = error_cnt + 1;
        conclude;
    end
    // Main sequence
    initial
    begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata, ex, src} = 0;
        wake_n = 1'b1;
        error_cnt = 0;
        check_count = 0;
        repeat (8) @(posedge hclk);
        chk({running, rom_addr}, 15'h0000);
        hresetn <= 1'b1;
        n = 0;
        do begin @(posedge hclk); #1; n = n + 1; end while (running !== 1'b1 && n < 100);
        chk(n >= ST && n <= ST + 2, 1);
        chk({phase, rom_addr}, {4'b0001, 14'h0000});
        for (k = 1; k < 4; k = k + 1)
        begin
            cyc(5'h00);
            chk({instr_valid, instr_word, rom_addr}, {1'b1, 2'b10, (k - 14'h1) ^ 14'h0AAA, k});
        end
        ahb(1, 32'h010, 32'h20);
        ahb(0, 32'h010, 0);
        chk(rd, 32'h20);
        ahb(0, 32'h200, 0);
        chk(rd, 0);
        chk({hresp, hreadyout}, 2'b01);
        cyc(5'h01);
        chk({instr_valid, rom_addr}, {1'b0, tgt(1'b1, pre)});
        ahb(1, 32'h010, 0);
        cyc(5'h00);
        chk(rom_addr[13], 1);
        cyc(5'h08);
        chk({instr_valid, rom_addr}, {1'b0, pre[13], pre[12:0] + 13'h1});
        cyc(5'h00);
        cyc(5'h02);
        r1 = pre;
        chk(rom_addr, tgt(1'b0, pre));
        ahb(0, 32'h108, 0);
        chk(rd[3:0], 4'h1);
        cyc(5'h00);
        cyc(5'h04);
        chk(rom_addr, r1);
        cyc(5'h00);
        ra = rom_addr;
        ahb(1, 32'h018, 32'h5C);
        @(posedge hclk);
        #1;
        chk(rom_addr, {ra[13:8], 8'h5C});
        ahb(0, 32'h018, 0);
        chk(rd, 32'h5C);
        for (k = 0; k < 5; k = k + 1)
        begin
            ahb(1, 32'h100, 32'h1 << k);
            pulse(5'h01 << k);
            vec(vaddr(k[2:0]));
            @(posedge hclk);
            src <= 5'h00;
            cyc(5'h00);
            cyc(5'h04);
            chk(rom_addr, ra);
        end
        ahb(1, 32'h100, 32'h06);
        pulse(5'h0E);
        vec(14'h0008);
        r1 = ra;
        vec(14'h0010);
        cyc(5'h00);
        cyc(5'h04);
        cyc(5'h00);
        cyc(5'h04);
        chk(rom_addr, r1);
        ahb(0, 32'h104, 0);
        chk(rd[4:0], 5'h08);
        ahb(1, 32'h104, 32'h08);
        ahb(0, 32'h104, 0);
        chk(rd[4:0], 5'h00);
        ahb(1, 32'h100, 32'h02);
        cyc(5'h00);
        for (k = 0; k < 8; k = k + 1)
        begin
            cyc(5'h02);
            cyc(5'h00);
        end
        pulse(5'h02);
        ahb(0, 32'h108, 0);
        chk(rd[3:0], 4'h8);
        ahb(0, 32'h104, 0);
        chk(rd[4:0], 5'h02);
        cyc(5'h04);
        vec(14'h0008);
        cyc(5'h00);
        cyc(5'h10);
        chk(running, 0);
        ahb(0, 32'h108, 0);
        chk(rd[6:4], 3'b010);
        @(posedge hclk);
        wake_n <= 1'b0;
        n = 0;
        do begin @(posedge hclk); #1; n = n + 1; end while (running !== 1'b1 && n < 100);
        chk(n >= ST && n <= ST + 4, 1);
        @(posedge hclk);
        wake_n <= 1'b1;
        conclude;
    end
endmodule // psv_sequencer_tb_top
bind psv_sequencer psv_seq_props #(.PC_W(PC_W), .STARTUP_CYC(STARTUP_CYC)) u_props (.hclk(hclk),
    .hresetn(hresetn), .phase(phase), .running(running), .rom_addr(rom_addr), .instr_word(instr_word),
    .instr_valid(instr_valid), .rom_data(rom_data), .exec_jump(exec_jump), .exec_call(exec_call),
    .exec_return(exec_return), .exec_skip(exec_skip));
